// [design/seq_defines.vh]
// constants for the engine start and stop sequencer
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH
// ----------------------------------------
// time base
// ----------------------------------------
`define CLK_HZ 100000000
`define TICK_SEC 1
`define TICK_CYCLES (`CLK_HZ * `TICK_SEC)
`define SEC_PER_MIN 16'h003c
// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_CTRL 6'h00
`define A_START_DLY 6'h01
`define A_PREHEAT 6'h02
`define A_CRANK 6'h03
`define A_WAIT 6'h04
`define A_STARTS 6'h05
`define A_HEAT 6'h06
`define A_HEAT_TEMP 6'h07
`define A_COOL 6'h08
`define A_STOP_SOL 6'h09
`define A_CHOKE 6'h0a
`define A_IDLE_RUN 6'h0b
`define A_IDLE_STOP 6'h0c
`define A_HOLDOFF 6'h0d
`define A_GAS 6'h0e
`define A_CUT_V 6'h0f
`define A_CUT_F 6'h10
`define A_CUT_RPM 6'h11
`define A_CUT_CHG 6'h12
`define A_OIL_DLY 6'h13
`define A_CHG_FAIL 6'h14
`define A_TANK 6'h15
`define A_FUEL_HR 6'h16
`define A_STATUS 6'h17
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define C_HEAT_METHOD 0
`define C_OIL_CUT 1
`define C_CHG_CUT 2
`define C_CLR_EVENTS 3
`define R_START_DLY 16'h0001
`define R_CRANK 16'h0006
`define R_WAIT 16'h000a
`define R_STARTS 16'h0003
`define R_HEAT 16'h0004
`define R_COOL 16'h0078
`define R_STOP_SOL 16'h000a
`define R_CHOKE 16'h0005
`define R_HOLDOFF 16'h000a
`define R_GAS 16'h0005
`define R_CUT_V 16'h0064
`define R_CUT_F 16'h000a
`define R_CUT_RPM 16'h01f4
`define R_CUT_CHG 16'h0006
`define R_OIL_DLY 16'h0002
`define R_CHG_FAIL 16'h0001
// ----------------------------------------
// states
// ----------------------------------------
`define S_IDLE 4'h0
`define S_DELAY 4'h1
`define S_PREHEAT 4'h2
`define S_CRANK 4'h3
`define S_WAIT 4'h4
`define S_RUNIDLE 4'h5
`define S_HEAT 4'h6
`define S_LOADED 4'h7
`define S_COOL 4'h8
`define S_STOPIDLE 4'h9
`define S_STOP 4'ha
`define S_FAILED 4'hb
`endif

// [design/engine_start_stop_sequencer.v]
// engine start and stop sequencer with register port
//
// Behaviour
// - charge fault after continuous low charge time
// - start delay minutes after mains fail
// - preheat output for preheat time
// - crank at most crank time, stop on fire
// - pause between attempts, limit attempt count
// - no load until heating method completes
// - cooldown unloaded before stop sequence
// - stop output bounded, then halt timeout warning
// - choke with crank, release on timer/run
// - idle output after start, low checks masked
// - idle output before stop, low checks masked
// - holdoff after idle keeps low checks masked
// - gas solenoid opens after gas delay
// - crank cut on phase one voltage
// - crank cut on generator frequency
// - crank cut on engine rpm
// - crank cut on charge voltage when enabled
// - oil crank cut after delay when enabled
// - oil indication ignored when cut disabled
// - fuel display suppressed at zero capacity
// - tank messages only with nonzero threshold
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "seq_defines.vh"

module engine_start_stop_sequencer #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter W = 16
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // register port
  input wire [5:0] reg_addr,
  input wire [W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [W-1:0] reg_rdata,
  // mains, load and sensors
  input wire mains_fail,
  input wire mains_back,
  input wire [W-1:0] gen_volt_l1,
  input wire [W-1:0] gen_freq,
  input wire [W-1:0] engine_rpm,
  input wire [W-1:0] charge_volt,
  input wire charge_low,
  input wire oil_switch_open,
  input wire oil_above_limit,
  input wire [W-1:0] coolant_temp,
  input wire tank_drop_det,
  input wire tank_refill_det,
  // relay outputs
  output reg fuel_output,
  output reg glow_plug_output,
  output reg crank_output,
  output reg air_restrict_output,
  output reg gas_output,
  output reg low_speed_output,
  output reg stop_output,
  // status outputs
  output reg load_ready,
  output reg low_checks_enable,
  output reg halt_timeout_warning,
  output reg charge_fault,
  output reg start_fail,
  output reg fuel_display_en,
  output reg tank_drop_message,
  output reg tank_refill_message
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [3:0] ctrl_r;
  reg [W-1:0] start_dly_r, preheat_r, crank_r, wait_r, starts_r, heat_r, heat_temp_r;
  reg [W-1:0] cool_r, stop_sol_r, choke_r, idle_run_r, idle_stop_r, holdoff_r, gas_r;
  reg [W-1:0] cut_v_r, cut_f_r, cut_rpm_r, cut_chg_r, oil_dly_r, chg_fail_r, tank_r, fuel_hr_r;

  // state
  reg [3:0] state_r;
  reg [W-1:0] tmr_r;
  reg [W-1:0] chk_tmr_r;
  reg [W-1:0] choke_tmr_r;
  reg [W-1:0] oil_tmr_r;
  reg [W-1:0] chg_tmr_r;
  reg [W-1:0] tries_r;
  reg [31:0] div_r;
  reg tick_r;
  reg choke_on_r;
  reg holdoff_r_act;

  // ----------------------------------------
  // one second tick
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (div_r == TICK_CYCLES - 1) begin
      div_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      ctrl_r <= 4'h0;
      start_dly_r <= `R_START_DLY;
      preheat_r <= 16'h0;
      crank_r <= `R_CRANK;
      wait_r <= `R_WAIT;
      starts_r <= `R_STARTS;
      heat_r <= `R_HEAT;
      heat_temp_r <= 16'h0;
      cool_r <= `R_COOL;
      stop_sol_r <= `R_STOP_SOL;
      choke_r <= `R_CHOKE;
      idle_run_r <= 16'h0;
      idle_stop_r <= 16'h0;
      holdoff_r <= `R_HOLDOFF;
      gas_r <= `R_GAS;
      cut_v_r <= `R_CUT_V;
      cut_f_r <= `R_CUT_F;
      cut_rpm_r <= `R_CUT_RPM;
      cut_chg_r <= `R_CUT_CHG;
      oil_dly_r <= `R_OIL_DLY;
      chg_fail_r <= `R_CHG_FAIL;
      tank_r <= 16'h0;
      fuel_hr_r <= 16'h0;
    end else begin
      ctrl_r[`C_CLR_EVENTS] <= 1'b0; // self clearing
      if (reg_wr) begin
        case (reg_addr)
          `A_CTRL: ctrl_r <= reg_wdata[3:0];
          `A_START_DLY: start_dly_r <= reg_wdata;
          `A_PREHEAT: preheat_r <= reg_wdata;
          `A_CRANK: crank_r <= reg_wdata;
          `A_WAIT: wait_r <= reg_wdata;
          `A_STARTS: starts_r <= reg_wdata;
          `A_HEAT: heat_r <= reg_wdata;
          `A_HEAT_TEMP: heat_temp_r <= reg_wdata;
          `A_COOL: cool_r <= reg_wdata;
          `A_STOP_SOL: stop_sol_r <= reg_wdata;
          `A_CHOKE: choke_r <= reg_wdata;
          `A_IDLE_RUN: idle_run_r <= reg_wdata;
          `A_IDLE_STOP: idle_stop_r <= reg_wdata;
          `A_HOLDOFF: holdoff_r <= reg_wdata;
          `A_GAS: gas_r <= reg_wdata;
          `A_CUT_V: cut_v_r <= reg_wdata;
          `A_CUT_F: cut_f_r <= reg_wdata;
          `A_CUT_RPM: cut_rpm_r <= reg_wdata;
          `A_CUT_CHG: cut_chg_r <= reg_wdata;
          `A_OIL_DLY: oil_dly_r <= reg_wdata;
          `A_CHG_FAIL: chg_fail_r <= reg_wdata;
          `A_TANK: tank_r <= reg_wdata;
          `A_FUEL_HR: fuel_hr_r <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // register reads, data one cycle later
  // ----------------------------------------
  reg [W-1:0] rd_mux;
  always @* begin
    case (reg_addr)
      `A_CTRL: rd_mux = {12'h0, ctrl_r};
      `A_START_DLY: rd_mux = start_dly_r;
      `A_PREHEAT: rd_mux = preheat_r;
      `A_CRANK: rd_mux = crank_r;
      `A_WAIT: rd_mux = wait_r;
      `A_STARTS: rd_mux = starts_r;
      `A_HEAT: rd_mux = heat_r;
      `A_HEAT_TEMP: rd_mux = heat_temp_r;
      `A_COOL: rd_mux = cool_r;
      `A_STOP_SOL: rd_mux = stop_sol_r;
      `A_CHOKE: rd_mux = choke_r;
      `A_IDLE_RUN: rd_mux = idle_run_r;
      `A_IDLE_STOP: rd_mux = idle_stop_r;
      `A_HOLDOFF: rd_mux = holdoff_r;
      `A_GAS: rd_mux = gas_r;
      `A_CUT_V: rd_mux = cut_v_r;
      `A_CUT_F: rd_mux = cut_f_r;
      `A_CUT_RPM: rd_mux = cut_rpm_r;
      `A_CUT_CHG: rd_mux = cut_chg_r;
      `A_OIL_DLY: rd_mux = oil_dly_r;
      `A_CHG_FAIL: rd_mux = chg_fail_r;
      `A_TANK: rd_mux = tank_r;
      `A_FUEL_HR: rd_mux = fuel_hr_r;
      `A_STATUS: rd_mux = {halt_timeout_warning, charge_fault, start_fail, tries_r[4:0], 4'h0, state_r};
      default: rd_mux = 16'h0; // unmapped reads zero
    endcase
  end

  always @(posedge mclk) begin
    if (srst)
      reg_rdata <= 16'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0;
  end

  // ----------------------------------------
  // crank cut conditions
  // ----------------------------------------
  wire fired_v = gen_volt_l1 >= cut_v_r;
  wire fired_f = gen_freq >= cut_f_r;
  wire fired_r = engine_rpm >= cut_rpm_r;
  wire fired_c = ctrl_r[`C_CHG_CUT] && (charge_volt >= cut_chg_r);
  // oil only counts when enabled, and only after its delay
  wire oil_ind = ctrl_r[`C_OIL_CUT] && (oil_switch_open || oil_above_limit);
  wire fired_o = oil_ind && (oil_tmr_r >= oil_dly_r);
  wire fired = fired_v || fired_f || fired_r || fired_c || fired_o;
  wire running = fired_v || fired_f || fired_r;
  // zero programmed time means expired at once
  wire tmr_done = tmr_r == 16'h0;
  wire [W-1:0] tmr_dec = tmr_done ? 16'h0 : (tick_r ? tmr_r - 16'h1 : tmr_r);
  wire heat_temp_ok = !ctrl_r[`C_HEAT_METHOD] || (coolant_temp >= heat_temp_r);
  // full product kept, then cut on purpose: 720 min fits 16 bits
  wire [2*W-1:0] dly_full = start_dly_r * `SEC_PER_MIN;
  wire [W-1:0] dly_sec = dly_full[W-1:0];

  // ----------------------------------------
  // sequence state machine
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      state_r <= `S_IDLE;
      tmr_r <= 16'h0;
      tries_r <= 16'h0;
      start_fail <= 1'b0;
      halt_timeout_warning <= 1'b0;
    end else begin
      tmr_r <= tmr_dec;
      if (ctrl_r[`C_CLR_EVENTS]) begin
        start_fail <= 1'b0;
        halt_timeout_warning <= 1'b0;
      end
      case (state_r)
        `S_IDLE: begin
          tries_r <= 16'h0;
          if (mains_fail) begin
            state_r <= `S_DELAY;
            tmr_r <= dly_sec;
          end
        end
        `S_DELAY: begin
          if (!mains_fail)
            state_r <= `S_IDLE;
          else if (tmr_done) begin
            state_r <= `S_PREHEAT;
            tmr_r <= preheat_r;
          end
        end
        `S_PREHEAT: begin
          if (tmr_done) begin
            state_r <= `S_CRANK;
            tmr_r <= crank_r;
            tries_r <= tries_r + 16'h1;
          end
        end
        `S_CRANK: begin
          if (fired) begin
            state_r <= `S_RUNIDLE;
            tmr_r <= idle_run_r;
          end else if (tmr_done) begin
            if (tries_r >= starts_r) begin
              state_r <= `S_FAILED;
              start_fail <= 1'b1;
            end else begin
              state_r <= `S_WAIT;
              tmr_r <= wait_r;
            end
          end
        end
        `S_WAIT: begin
          if (tmr_done) begin
            state_r <= `S_CRANK;
            tmr_r <= crank_r;
            tries_r <= tries_r + 16'h1;
          end
        end
        `S_RUNIDLE: begin
          if (tmr_done) begin
            state_r <= `S_HEAT;
            tmr_r <= heat_r;
          end
        end
        `S_HEAT: begin
          if (tmr_done && heat_temp_ok)
            state_r <= `S_LOADED;
        end
        `S_LOADED: begin
          if (mains_back) begin
            state_r <= `S_COOL;
            tmr_r <= cool_r;
          end
        end
        `S_COOL: begin
          if (tmr_done) begin
            state_r <= `S_STOPIDLE;
            tmr_r <= idle_stop_r;
          end
        end
        `S_STOPIDLE: begin
          if (tmr_done) begin
            state_r <= `S_STOP;
            tmr_r <= stop_sol_r;
          end
        end
        `S_STOP: begin
          if (tmr_done) begin
            state_r <= `S_IDLE;
            if (running)
              halt_timeout_warning <= 1'b1;
          end
        end
        `S_FAILED: begin
          if (!mains_fail)
            state_r <= `S_IDLE;
        end
        default: state_r <= `S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // per crank timers: choke, gas and oil delay
  // ----------------------------------------
  wire in_crank = state_r == `S_CRANK;
  always @(posedge mclk) begin
    if (srst) begin
      choke_tmr_r <= 16'h0;
      oil_tmr_r <= 16'h0;
      choke_on_r <= 1'b0;
    end else if (!in_crank) begin
      choke_tmr_r <= 16'h0;
      oil_tmr_r <= 16'h0;
      choke_on_r <= 1'b1;
    end else begin
      if (tick_r && choke_tmr_r != 16'hffff)
        choke_tmr_r <= choke_tmr_r + 16'h1;
      if (!oil_ind)
        oil_tmr_r <= 16'h0;
      else if (tick_r && oil_tmr_r != 16'hffff)
        oil_tmr_r <= oil_tmr_r + 16'h1;
      if (running || choke_tmr_r >= choke_r)
        choke_on_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // idle holdoff and charge supervision
  // ----------------------------------------
  wire idle_act = state_r == `S_RUNIDLE || state_r == `S_STOPIDLE;
  always @(posedge mclk) begin
    if (srst) begin
      chk_tmr_r <= 16'h0;
      holdoff_r_act <= 1'b0;
      chg_tmr_r <= 16'h0;
      charge_fault <= 1'b0;
    end else begin
      if (idle_act) begin
        chk_tmr_r <= holdoff_r;
        holdoff_r_act <= 1'b1;
      end else if (chk_tmr_r == 16'h0)
        holdoff_r_act <= 1'b0;
      else if (tick_r)
        chk_tmr_r <= chk_tmr_r - 16'h1;
      // set wins over the clear request
      if (!charge_low)
        chg_tmr_r <= 16'h0;
      else if (tick_r && chg_tmr_r != 16'hffff)
        chg_tmr_r <= chg_tmr_r + 16'h1;
      if (charge_low && chg_tmr_r >= chg_fail_r)
        charge_fault <= 1'b1;
      else if (ctrl_r[`C_CLR_EVENTS])
        charge_fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      fuel_output <= 1'b0;
      glow_plug_output <= 1'b0;
      crank_output <= 1'b0;
      air_restrict_output <= 1'b0;
      gas_output <= 1'b0;
      low_speed_output <= 1'b0;
      stop_output <= 1'b0;
      load_ready <= 1'b0;
      low_checks_enable <= 1'b0;
      fuel_display_en <= 1'b0;
      tank_drop_message <= 1'b0;
      tank_refill_message <= 1'b0;
    end else begin
      fuel_output <= state_r >= `S_PREHEAT && state_r <= `S_STOPIDLE;
      glow_plug_output <= state_r == `S_PREHEAT;
      crank_output <= in_crank && !fired;
      air_restrict_output <= in_crank && choke_on_r && !running;
      gas_output <= in_crank && choke_tmr_r >= gas_r;
      low_speed_output <= idle_act;
      stop_output <= state_r == `S_STOP && running;
      load_ready <= state_r == `S_LOADED;
      low_checks_enable <= state_r >= `S_RUNIDLE && state_r <= `S_COOL && !idle_act && !holdoff_r_act;
      fuel_display_en <= tank_r != 16'h0;
      tank_drop_message <= fuel_hr_r != 16'h0 && tank_drop_det;
      tank_refill_message <= fuel_hr_r != 16'h0 && tank_refill_det;
    end
  end

endmodule // engine_start_stop_sequencer

// [bench/seq_chk.sv]
// concurrent checks for the engine start and stop sequencer
`timescale 1ns/1ps
`include "seq_defines.vh"
module seq_chk #(
  parameter TICK_CYCLES = 10,
  parameter W = 16
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // sensors
  input wire [W-1:0] gen_volt_l1,
  input wire [W-1:0] gen_freq,
  input wire [W-1:0] engine_rpm,
  // relays and status
  input wire fuel_output,
  input wire crank_output,
  input wire gas_output,
  input wire low_speed_output,
  input wire low_checks_enable,
  input wire stop_output,
  input wire start_fail
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // run lengths of crank and stop relays
  int crank_n;
  int stop_n;
  always @(posedge mclk) begin
    crank_n <= (srst || !crank_output) ? 0 : crank_n + 1;
    stop_n <= (srst || !stop_output) ? 0 : stop_n + 1;
  end
  // crank must drop one or two cycles after a cut
  sequence s_cut_drop;
    ##[1:2] !crank_output;
  endsequence
  property p_cut_volt;
    crank_output && gen_volt_l1 >= `R_CUT_V |-> s_cut_drop;
  endproperty
  property p_cut_freq;
    crank_output && gen_freq >= `R_CUT_F |-> s_cut_drop;
  endproperty
  property p_cut_rpm;
    crank_output && engine_rpm >= `R_CUT_RPM |-> s_cut_drop;
  endproperty
  property p_crank_fuel;
    crank_output |-> fuel_output || $past(fuel_output);
  endproperty
  // one tick of jitter allowed on every second count
  property p_gas_delay;
    $rose(gas_output) |-> crank_n >= (`R_GAS - 1) * TICK_CYCLES - 2;
  endproperty
  property p_crank_len;
    crank_n <= (`R_CRANK + 1) * TICK_CYCLES + 2;
  endproperty
  property p_stop_len;
    stop_n <= (`R_STOP_SOL + 1) * TICK_CYCLES + 2;
  endproperty
  property p_idle_mask;
    low_speed_output && $past(low_speed_output) |-> !low_checks_enable;
  endproperty
  property p_holdoff;
    $fell(low_speed_output) |-> !low_checks_enable [*8];
  endproperty
  property p_fail_release;
    $rose(start_fail) |-> ##[0:2] (!fuel_output && !crank_output);
  endproperty
  a_cut_volt: assert property (p_cut_volt) else $error("crank held after voltage cut");
  a_cut_freq: assert property (p_cut_freq) else $error("crank held after frequency cut");
  a_cut_rpm: assert property (p_cut_rpm) else $error("crank held after rpm cut");
  a_crank_fuel: assert property (p_crank_fuel) else $error("crank without fuel");
  a_gas_delay: assert property (p_gas_delay) else $error("gas opened early");
  a_crank_len: assert property (p_crank_len) else $error("crank too long");
  a_stop_len: assert property (p_stop_len) else $error("stop relay too long");
  a_idle_mask: assert property (p_idle_mask) else $error("low checks during idle");
  a_holdoff: assert property (p_holdoff) else $error("low checks before holdoff");
  a_fail_release: assert property (p_fail_release) else $error("relays held after start failure");
endmodule // seq_chk

bind engine_start_stop_sequencer seq_chk #(.TICK_CYCLES(TICK_CYCLES), .W(W)) i_chk (
  .mclk(mclk), .srst(srst), .gen_volt_l1(gen_volt_l1), .gen_freq(gen_freq), .engine_rpm(engine_rpm),
  .fuel_output(fuel_output), .crank_output(crank_output), .gas_output(gas_output),
  .low_speed_output(low_speed_output), .low_checks_enable(low_checks_enable),
  .stop_output(stop_output), .start_fail(start_fail)
);

// [bench/engine_model.sv]
// behavioural engine and alternator model driven by the relays
`timescale 1ns/1ps
module engine_model (
  // clock and reset
  input wire mclk,
  input wire srst,
  // relays
  input wire fuel_output,
  input wire crank_output,
  input wire stop_output,
  // scenario controls
  input wire [7:0] fire_dly,
  input wire stuck,
  // measured quantities
  output wire [15:0] gen_volt_l1,
  output wire [15:0] gen_freq,
  output wire [15:0] engine_rpm,
  output wire [15:0] charge_volt
);
  reg running_r;
  reg [7:0] crank_cnt_r;
  // fires after fire_dly crank cycles, zero never fires; stuck ignores stop
  always @(posedge mclk) begin
    if (srst) begin
      running_r <= 1'b0;
      crank_cnt_r <= 8'h00;
    end else begin
      crank_cnt_r <= crank_output ? crank_cnt_r + 8'h01 : 8'h00;
      if (crank_output && fire_dly != 8'h00 && crank_cnt_r >= fire_dly)
        running_r <= 1'b1;
      else if (!stuck && (stop_output || !fuel_output))
        running_r <= 1'b0;
    end
  end
  // a stopped engine really measures zero on every channel
  assign gen_volt_l1 = running_r ? 16'h00e6 : 16'h0000;
  assign gen_freq = running_r ? 16'h0032 : 16'h0000;
  assign engine_rpm = running_r ? 16'h05dc : 16'h0000;
  assign charge_volt = running_r ? 16'h000d : 16'h0000;
endmodule // engine_model

// [bench/engine_start_stop_sequencer_test.sv]
// self-checking bench for the engine start and stop sequencer
`timescale 1ns/1ps
`include "seq_defines.vh"
module engine_start_stop_sequencer_test;
  localparam int T = 10;
  localparam int FUEL = 0, GLOW = 1, CRANK = 2, AIR = 3, GAS = 4, LOWSPD = 5, STOP = 6, LOAD = 7;
  localparam int LOWCHK = 8, HALT = 9, CHG = 10, SFAIL = 11, FDISP = 12, TDROP = 13, TREF = 14;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg [5:0] reg_addr = 6'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0, reg_rd = 1'b0, mains_fail = 1'b0, mains_back = 1'b0, charge_low = 1'b0;
  reg oil_switch_open = 1'b0, oil_above_limit = 1'b0, tank_drop_det = 1'b0, tank_refill_det = 1'b0;
  reg [15:0] coolant_temp = 16'h0000;
  reg [7:0] fire_dly = 8'h08;
  reg stuck = 1'b0;
  wire [15:0] reg_rdata, gen_volt_l1, gen_freq, engine_rpm, charge_volt;
  wire fuel_output, glow_plug_output, crank_output, air_restrict_output, gas_output, low_speed_output;
  wire stop_output, load_ready, low_checks_enable, halt_timeout_warning, charge_fault, start_fail;
  wire fuel_display_en, tank_drop_message, tank_refill_message;
  wire [14:0] obs = {tank_refill_message, tank_drop_message, fuel_display_en, start_fail, charge_fault,
    halt_timeout_warning, low_checks_enable, load_ready, stop_output, low_speed_output, gas_output,
    air_restrict_output, crank_output, glow_plug_output, fuel_output};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  engine_start_stop_sequencer #(.TICK_CYCLES(T)) i_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mains_fail(mains_fail),
    .mains_back(mains_back), .gen_volt_l1(gen_volt_l1), .gen_freq(gen_freq), .engine_rpm(engine_rpm),
    .charge_volt(charge_volt), .charge_low(charge_low), .oil_switch_open(oil_switch_open),
    .oil_above_limit(oil_above_limit), .coolant_temp(coolant_temp), .tank_drop_det(tank_drop_det),
    .tank_refill_det(tank_refill_det), .fuel_output(fuel_output), .glow_plug_output(glow_plug_output),
    .crank_output(crank_output), .air_restrict_output(air_restrict_output), .gas_output(gas_output),
    .low_speed_output(low_speed_output), .stop_output(stop_output), .load_ready(load_ready),
    .low_checks_enable(low_checks_enable), .halt_timeout_warning(halt_timeout_warning),
    .charge_fault(charge_fault), .start_fail(start_fail), .fuel_display_en(fuel_display_en),
    .tank_drop_message(tank_drop_message), .tank_refill_message(tank_refill_message));
  engine_model i_eng (.mclk(mclk), .srst(srst), .fuel_output(fuel_output), .crank_output(crank_output),
    .stop_output(stop_output), .fire_dly(fire_dly), .stuck(stuck), .gen_volt_l1(gen_volt_l1),
    .gen_freq(gen_freq), .engine_rpm(engine_rpm), .charge_volt(charge_volt));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [5:0] a, input [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [5:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait on one output, n returns elapsed cycles
  task waitfor(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task do_reset;
    @(posedge mclk);
    srst <= 1'b1; mains_fail <= 1'b0; mains_back <= 1'b0; coolant_temp <= 16'h0000;
    fire_dly <= 8'h08; stuck <= 1'b0; oil_switch_open <= 1'b0; charge_low <= 1'b0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    logic [15:0] d;
    rd(`A_CRANK, d); check("crank time", d, `R_CRANK);
    rd(`A_WAIT, d); check("wait time", d, `R_WAIT);
    rd(`A_STARTS, d); check("starts", d, `R_STARTS);
    rd(`A_CUT_RPM, d); check("cut rpm", d, `R_CUT_RPM);
    rd(6'h3f, d); check("unmapped", d, 16'h0000);
    wr(`A_STATUS, 16'hffff);
    rd(`A_STATUS, d); check("status ro", d, 16'h0000);
  endtask
  // full start, load, cooldown and stop; hot uses method 1, stk keeps engine turning
  task t_run(input logic hot, input logic stk);
    int n;
    do_reset;
    wr(`A_PREHEAT, 16'h0002); wr(`A_IDLE_RUN, 16'h0001); wr(`A_HEAT, 16'h0003); wr(`A_COOL, 16'h0002);
    wr(`A_IDLE_STOP, 16'h0001); wr(`A_STOP_SOL, 16'h0003); wr(`A_HEAT_TEMP, 16'h0032);
    wr(`A_CTRL, {15'h0000, hot});
    if (hot) wr(`A_START_DLY, 16'h0000);
    stuck <= stk;
    mains_fail <= 1'b1;
    waitfor(FUEL, 1'b1, 70 * T, n);
    check("start delay", hot || (n >= 59 * T && n <= 61 * T + 5), 1'b1);
    waitfor(GLOW, 1'b1, 3, n); check("glow", obs[GLOW], 1'b1);
    waitfor(CRANK, 1'b1, 4 * T, n); check("preheat", n >= T && n <= 2 * T + 5, 1'b1);
    @(posedge mclk);
    #1 check("choke", obs[AIR], 1'b1);
    waitfor(CRANK, 1'b0, 2 * T, n); check("crank cut", obs[CRANK], 1'b0);
    waitfor(LOWSPD, 1'b1, 5, n); check("run idle", obs[LOWSPD], 1'b1);
    check("choke release", obs[AIR], 1'b0);
    if (hot) begin
      waitfor(LOAD, 1'b1, 8 * T, n); check("heat temp", obs[LOAD], 1'b0);
      coolant_temp <= 16'h003c;
    end
    waitfor(LOAD, 1'b1, 8 * T, n); check("load", obs[LOAD], 1'b1);
    check("heat time", hot || n >= 2 * T, 1'b1);
    check("holdoff", obs[LOWCHK], 1'b0);
    waitfor(LOWCHK, 1'b1, 12 * T, n); check("checks on", obs[LOWCHK], 1'b1);
    mains_fail <= 1'b0;
    mains_back <= 1'b1;
    waitfor(STOP, 1'b1, 10 * T, n); check("cooldown", n >= 2 * T && n <= 5 * T + 5, 1'b1);
    repeat (4 * T + 5) @(posedge mclk);
    #1 check("halt warning", obs[HALT], stk);
  endtask
  // engine never fires, oil indication present but its cut disabled
  task t_fail;
    int ncr, len;
    logic pc, gs;
    ncr = 0; len = 0; pc = 1'b0; gs = 1'b0;
    do_reset;
    wr(`A_START_DLY, 16'h0000); wr(`A_STARTS, 16'h0002); wr(`A_WAIT, 16'h0001);
    fire_dly <= 8'h00; oil_switch_open <= 1'b1; mains_fail <= 1'b1;
    for (int i = 0; i < 30 * T; i++) begin
      @(posedge mclk);
      #1 if (obs[CRANK] && !pc) ncr++;
      pc = obs[CRANK];
      if (pc) len++;
      gs = gs | obs[GAS];
    end
    check("attempts", ncr, 2);
    check("full crank", len >= 2 * (`R_CRANK - 1) * T, 1'b1);
    check("gas opened", gs, 1'b1);
    check("start fail", obs[SFAIL], 1'b1);
    check("fuel off", obs[FUEL], 1'b0);
  endtask
  task t_oil;
    int n;
    do_reset;
    wr(`A_START_DLY, 16'h0000); wr(`A_CTRL, 16'h0002);
    fire_dly <= 8'h00; oil_switch_open <= 1'b1; mains_fail <= 1'b1;
    waitfor(CRANK, 1'b1, 3 * T, n);
    waitfor(CRANK, 1'b0, 8 * T, n); check("oil cut", n >= T && n <= 3 * T + 5, 1'b1);
  endtask
  task t_misc;
    int n;
    do_reset;
    charge_low <= 1'b1;
    waitfor(CHG, 1'b1, 3 * T, n); check("charge fault", obs[CHG], 1'b1);
    check("no display", obs[FDISP], 1'b0);
    wr(`A_TANK, 16'h0064);
    tank_drop_det <= 1'b1; tank_refill_det <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("display", obs[FDISP], 1'b1);
    check("msgs off", obs[TREF:TDROP], 2'b00);
    wr(`A_FUEL_HR, 16'h0005);
    repeat (3) @(posedge mclk);
    #1 check("msgs on", obs[TREF:TDROP], 2'b11);
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    do_reset;
    t_regs;
    t_run(1'b0, 1'b0);
    t_run(1'b1, 1'b1);
    t_fail;
    t_oil;
    t_misc;
    results();
  end
endmodule // engine_start_stop_sequencer_test
